/* dv/dtuc_asserts.sv */
/*
 Checker for the sequencing block: bus answer, conversion pulse, interrupt and DAC relations.
 Assumes it is bound onto dtuc_core, one clock, reset low.
*/
module dtuc_asserts
	import dtuc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ext_dac_update_n,
	input wire logic        adc_convert,
	input wire logic [11:0] dac0_out,
	input wire logic        host_interrupt
);
	logic [4:0] upd_hist_reg;
	wire        upd_quiet = &upd_hist_reg;
	wire        acc       = psel && penable && pwrite;
	wire        clr       = acc && paddr == DTUC_OFF_CMD && pwdata[DTUC_CMD_INTCLR];
	wire        wr0       = acc && paddr == DTUC_OFF_DAC0;
	// Long enough to span both sync stages and the output register
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			upd_hist_reg <= 5'h1f;
		else
			upd_hist_reg <= {upd_hist_reg[3:0], ext_dac_update_n};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PREADY_ONE: assert property (psel && !penable |=> pready)
		else $error("no answer in access cycle");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_UNMAPPED_ERR: assert property (psel && penable && paddr > DTUC_OFF_CMD |-> pslverr)
		else $error("unmapped access not refused");
	AST_ERR_RDATA_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	AST_CONV_PULSE: assert property (adc_convert |=> !adc_convert)
		else $error("conversion strobe not one cycle");
	AST_IRQ_HOLD: assert property (host_interrupt && !clr |=> host_interrupt)
		else $error("interrupt dropped without clear");
	AST_IRQ_CLEAR: assert property (host_interrupt && clr && upd_quiet |=> !host_interrupt)
		else $error("interrupt not cleared");
	AST_DAC0_CAUSE: assert property ($changed(dac0_out) && upd_quiet |-> $past(wr0, 1) || $past(wr0, 2))
		else $error("dac0 changed without write or update level");
	cover property (adc_convert);
	cover property (host_interrupt && clr);
	cover property (pslverr);
endmodule : dtuc_asserts

bind dtuc_core dtuc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_dac_update_n(ext_dac_update_n), .adc_convert(adc_convert), .dac0_out(dac0_out),
	.host_interrupt(host_interrupt));

/* dv/dtuc_pins.sv */
/*
 Model of the external instruments on the conversion, trigger and update pins.
 Assumes strobe and update pins idle high, trigger idles low.
*/
module dtuc_pins
(
	input  wire logic pclk,
	output logic      ext_convert_n,
	output logic      ext_trigger,
	output logic      ext_dac_update_n,
	output logic      general_counter1_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		ext_convert_n = 1'b1;
		ext_trigger = 1'b0;
		ext_dac_update_n = 1'b1;
		general_counter1_out = 1'b0;
	end
	// Each level held six cycles, twice the minimum the pins need
	task automatic conv(input int n);
		repeat (n)
		begin
			repeat (6) @(posedge pclk);
			ext_convert_n <= 1'b0;
			repeat (6) @(posedge pclk);
			ext_convert_n <= 1'b1;
		end
	endtask : conv
	task automatic trig;
		repeat (6) @(posedge pclk);
		ext_trigger <= 1'b1;
		repeat (6) @(posedge pclk);
		ext_trigger <= 1'b0;
	endtask : trig
	// Rises far enough apart for one full interval each
	task automatic gpc1(input int n);
		repeat (n)
		begin
			repeat (6) @(posedge pclk);
			general_counter1_out <= 1'b1;
			repeat (30) @(posedge pclk);
			general_counter1_out <= 1'b0;
		end
	endtask : gpc1
	task automatic upd(input logic v);
		@(posedge pclk);
		ext_dac_update_n <= v;
	endtask : upd
endmodule : dtuc_pins

/* dv/tb_top.sv */
/*
 Testbench: APB tasks and pin sequences with expected values.
 Assumes dtuc_core without wait states and the pin model beside it.
*/
module tb_top
	import dtuc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire logic   conv_n_pin, trig_pin, upd_pin, gc1_pin;
	logic        adc_convert;
	logic [11:0] dac0_out;
	logic [11:0] dac1_out;
	logic        host_interrupt;
	logic [31:0] rd;
	logic        er;
	int          fail_count = 0;
	int          comparisons = 0;
	int          conv_cnt = 0;

	always #4 pclk = ~pclk;
	always @(posedge pclk)
		if (adc_convert === 1'b1)
			conv_cnt++;

	dtuc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_convert_n(conv_n_pin), .ext_trigger(trig_pin), .ext_dac_update_n(upd_pin),
		.general_counter1_out(gc1_pin), .adc_convert(adc_convert), .dac0_out(dac0_out),
		.dac1_out(dac1_out), .host_interrupt(host_interrupt));
	dtuc_pins pins (.pclk(pclk), .ext_convert_n(conv_n_pin), .ext_trigger(trig_pin),
		.ext_dac_update_n(upd_pin), .general_counter1_out(gc1_pin));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Waits for pready however long it takes; the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle
	task automatic arm(input logic [31:0] ctrl);
		apb(1'b1, DTUC_OFF_CTRL, ctrl);
		apb(1'b1, DTUC_OFF_CMD, 32'h0000_0001);
		conv_cnt = 0;
	endtask : arm
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (2000) @(posedge pclk);
		fail_count++;
		test_done;
	end

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, DTUC_OFF_CTRL, 32'h0000_0000);
		chk("ctrl", rd, {24'h00_0000, DTUC_CTRL_RST});
		chk("irq rst", {31'h0, host_interrupt}, 32'h0000_0000);
		apb(1'b0, DTUC_OFF_COUNT, 32'h0000_0000);
		chk("count", rd, {16'h0000, DTUC_COUNT_RST});
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk("unmapped err", {31'h0, er}, 32'h0000_0001);
		apb(1'b1, DTUC_OFF_COUNT, 32'h0000_FFFF);
		apb(1'b0, DTUC_OFF_COUNT, 32'h0000_0000);
		chk("count max", rd, 32'h0000_FFFF);
		apb(1'b1, DTUC_OFF_COUNT, {16'h0000, DTUC_COUNT_RST});
		// Both trigger modes requested: only pretrigger stays
		apb(1'b1, DTUC_OFF_CTRL, 32'h0000_000C);
		apb(1'b0, DTUC_OFF_CTRL, 32'h0000_0000);
		chk("one mode", rd, 32'h0000_0008);
		$display("test reset done");
		arm(32'h0000_0007);
		pins.conv(2);
		idle(8);
		chk("gated", conv_cnt, 32'h0000_0000);
		pins.trig;
		pins.conv(3);
		pins.trig;
		pins.conv(5);
		idle(8);
		chk("post count", conv_cnt, 32'h0000_0005);
		$display("test posttrigger done");
		arm(32'h0000_000B);
		pins.conv(3);
		idle(8);
		chk("pre count", conv_cnt, 32'h0000_0003);
		conv_cnt = 0;
		pins.trig;
		pins.conv(8);
		idle(8);
		chk("pre stop", conv_cnt, 32'h0000_0005);
		$display("test pretrigger done");
		arm(32'h0000_0017);
		pins.trig;
		pins.conv(8);
		idle(8);
		chk("free count", conv_cnt, 32'h0000_0007);
		$display("test freerun done");
		arm(32'h0000_0001);
		idle(120);
		chk("timed count", conv_cnt, 32'h0000_0005);
		$display("test timed done");
		arm(32'h0000_0031);
		idle(40);
		chk("interval idle", conv_cnt, 32'h0000_0000);
		pins.gpc1(2);
		idle(8);
		chk("interval count", conv_cnt, 32'h0000_0002);
		$display("test interval done");
		apb(1'b1, DTUC_OFF_DAC0, 32'h0000_0123);
		apb(1'b1, DTUC_OFF_DAC1, 32'h0000_0456);
		idle(3);
		chk("dac0 imm", {20'h0_0000, dac0_out}, 32'h0000_0123);
		chk("dac1 imm", {20'h0_0000, dac1_out}, 32'h0000_0456);
		apb(1'b1, DTUC_OFF_CTRL, 32'h0000_00C0);
		apb(1'b1, DTUC_OFF_DAC0, 32'h0000_00AB);
		idle(8);
		chk("dac0 held", {20'h0_0000, dac0_out}, 32'h0000_0123);
		pins.upd(1'b0);
		idle(8);
		chk("dac0 later", {20'h0_0000, dac0_out}, 32'h0000_00AB);
		apb(1'b1, DTUC_OFF_DAC1, 32'h0000_0789);
		idle(3);
		chk("dac1 low", {20'h0_0000, dac1_out}, 32'h0000_0789);
		pins.upd(1'b1);
		idle(8);
		chk("irq set", {31'h0, host_interrupt}, 32'h0000_0001);
		idle(20);
		chk("irq held", {31'h0, host_interrupt}, 32'h0000_0001);
		apb(1'b1, DTUC_OFF_CMD, 32'h0000_0002);
		idle(2);
		chk("irq clr", {31'h0, host_interrupt}, 32'h0000_0000);
		$display("test dac done");
		test_done;
	end
endmodule : tb_top

/* rtl/dtuc_core.sv */
/*
 Conversion sequencer and DAC update controller with an APB register file.
 Assumes external pins are asynchronous to pclk and are synchronised here;
 the ADC and DACs sit outside and take one-cycle strobes and held codes.
*/
// Our own choices: the APB interface to the registers and the address map.
// Notes on behaviour
// - Dedicated interval and sample counters, not shared
// - External strobe falling edge starts one conversion
// - Posttrigger or pretrigger, never both
// - Posttrigger: interval counter gated until trigger rise
// - External timing waits strobe rise after trigger
// - Later trigger edges ignored until re-armed
// - Controlled mode: sample count expiry stops conversions
// - Count loads late, two extra conversions
// - Trigger also starts free-run, count ignored
// - Pretrigger: convert early, sample counter gated
// - Pretrigger needs controlled mode, two extra conversions
// - Post-trigger count up to 65535
// - Counter 1 output starts interval timing
// - Immediate mode: DAC follows writes
// - Later mode: transfer while update pin low
// - Write during low update level applies immediately
// - Update rising edge raises interrupt when enabled
// - Interrupt held until interrupt_clear
module dtuc_core
	import dtuc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_convert_n,
	input  wire logic        ext_trigger,
	input  wire logic        ext_dac_update_n,
	input  wire logic        general_counter1_out,
	output logic             adc_convert,
	output logic      [11:0] dac0_out,
	output logic      [11:0] dac1_out,
	output logic             host_interrupt
);

	function automatic logic [15:0] dec16(input logic [15:0] v);
		dec16 = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
	endfunction : dec16

	logic [7:0]  ctrl_reg;
	logic [15:0] interval_reg;
	logic [15:0] count_reg;
	logic [11:0] dac0_hold_reg;
	logic [11:0] dac1_hold_reg;
	logic [11:0] dac0_reg;
	logic [11:0] dac1_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        conv_reg;
	logic        irq_reg;
	logic        trig_seen_reg;
	logic [15:0] interval_cnt_reg;
	logic [15:0] sample_cnt_reg;
	logic        sample_loaded_reg;
	logic        sample_clk_seen_reg;
	logic        intv_go_reg;
	logic        gpc1_meta_reg;
	logic        gpc1_sync_reg;
	logic        gpc1_last_reg;
	dtuc_state_t state_reg;
	dtuc_state_t state_next;

	logic conv_lvl, conv_rise, conv_fall;
	logic trig_rise;
	logic upd_lvl,  upd_rise;

	dtuc_sync #(.RST_VAL (1'b1)) u_sync_conv (
		.pclk      (pclk),
		.presetn   (presetn),
		.async_in  (ext_convert_n),
		.level     (conv_lvl),
		.rise      (conv_rise),
		.fall      (conv_fall)
	);

	// Trigger idles low, so its stages reset low
	dtuc_sync #(.RST_VAL (1'b0)) u_sync_trig (
		.pclk      (pclk),
		.presetn   (presetn),
		.async_in  (ext_trigger),
		.level     (),
		.rise      (trig_rise),
		.fall      ()
	);

	dtuc_sync #(.RST_VAL (1'b1)) u_sync_upd (
		.pclk      (pclk),
		.presetn   (presetn),
		.async_in  (ext_dac_update_n),
		.level     (upd_lvl),
		.rise      (upd_rise),
		.fall      ()
	);

	// Counter 1 output from outside the domain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gpc1_meta_reg <= 1'b0;
			gpc1_sync_reg <= 1'b0;
			gpc1_last_reg <= 1'b0;
		end
		else
		begin
			gpc1_meta_reg <= general_counter1_out;
			gpc1_sync_reg <= gpc1_meta_reg;
			gpc1_last_reg <= gpc1_sync_reg;
		end
	end

	// Bus decode
	wire setup_w   = psel & ~penable;
	wire access_w  = psel & penable;
	wire wr_w      = access_w & pwrite;
	wire hit_ctrl  = (paddr == DTUC_OFF_CTRL);
	wire hit_int   = (paddr == DTUC_OFF_INTERVAL);
	wire hit_cnt   = (paddr == DTUC_OFF_COUNT);
	wire hit_dac0  = (paddr == DTUC_OFF_DAC0);
	wire hit_dac1  = (paddr == DTUC_OFF_DAC1);
	wire hit_stat  = (paddr == DTUC_OFF_STATUS);
	wire hit_cmd   = (paddr == DTUC_OFF_CMD);
	wire hit_any   = hit_ctrl | hit_int | hit_cnt | hit_dac0 | hit_dac1 | hit_stat | hit_cmd;

	wire wr_ctrl   = wr_w & hit_ctrl;
	wire wr_dac0   = wr_w & hit_dac0;
	wire wr_dac1   = wr_w & hit_dac1;
	wire cmd_arm   = wr_w & hit_cmd & pwdata[DTUC_CMD_ARM];
	wire int_clear = wr_w & hit_cmd & pwdata[DTUC_CMD_INTCLR];

	// Pretrigger wins if software sets both
	wire [7:0] ctrl_wdata = {pwdata[7:4],
	                         pwdata[DTUC_CTRL_PRETRIGGER_MODE],
	                         pwdata[DTUC_CTRL_POSTTRIG] & ~pwdata[DTUC_CTRL_PRETRIGGER_MODE],
	                         pwdata[1:0]};

	wire en_w       = ctrl_reg[DTUC_CTRL_ENABLE];
	wire ext_convert_n_w  = ctrl_reg[DTUC_CTRL_EXT_CONVERT_N];
	wire post_w     = ctrl_reg[DTUC_CTRL_POSTTRIG];
	// Pretrigger forces controlled counting regardless of free-run bit
	wire pre_w      = ctrl_reg[DTUC_CTRL_PRETRIGGER_MODE];
	wire freerun_w  = ctrl_reg[DTUC_CTRL_FREERUN] & ~pre_w;
	wire intv_w     = ctrl_reg[DTUC_CTRL_INTERVAL];
	wire later_w    = ctrl_reg[DTUC_CTRL_LATERUPD];
	wire updint_w   = ctrl_reg[DTUC_CTRL_UPDINT_EN];

	// Trigger accepted once per armed sequence
	wire trig_take  = trig_rise & ~trig_seen_reg & (post_w | pre_w);

	// Interval counter pacing; in interval mode each counter 1 rise paces one interval
	wire gpc1_rise   = gpc1_sync_reg & ~gpc1_last_reg;
	wire intv_count  = ~intv_w | intv_go_reg;
	wire intv_tick   = (interval_cnt_reg == 16'h0000);
	wire timed_pulse = (state_reg == DTUC_RUN) & ~ext_convert_n_w & intv_tick & intv_count;
	wire ext_pulse  = (state_reg == DTUC_RUN) & ext_convert_n_w & conv_fall;
	wire conv_pulse = timed_pulse | ext_pulse;

	// Sample counter: clocked by conversions, armed only by its gate
	wire sample_gate = ~pre_w | trig_seen_reg;
	wire sample_done = sample_loaded_reg & (sample_cnt_reg == 16'h0000) & ~freerun_w;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			DTUC_IDLE:
				state_next = DTUC_IDLE;
			DTUC_WAIT_TRIG:
				if (trig_take)
					state_next = (ext_convert_n_w & conv_lvl) ? DTUC_WAIT_CONV_HIGH : DTUC_RUN;
			DTUC_WAIT_CONV_HIGH:
				if (conv_rise)
					state_next = DTUC_RUN;
			DTUC_RUN:
				if (sample_done)
					state_next = DTUC_DONE;
			DTUC_DONE:
				state_next = DTUC_DONE;
			default:
				state_next = DTUC_IDLE;
		endcase
		// Arming starts a new sequence from any state, DONE included
		if (cmd_arm & en_w)
			state_next = post_w ? DTUC_WAIT_TRIG : DTUC_RUN;
		if (~en_w)
			state_next = DTUC_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg           <= DTUC_IDLE;
			trig_seen_reg       <= 1'b0;
			interval_cnt_reg    <= DTUC_INTERVAL_RST;
			sample_cnt_reg      <= DTUC_COUNT_RST;
			sample_loaded_reg   <= 1'b0;
			sample_clk_seen_reg <= 1'b0;
			conv_reg            <= 1'b0;
			intv_go_reg         <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			if (cmd_arm)
				trig_seen_reg <= 1'b0;
			else if (trig_take)
				trig_seen_reg <= 1'b1;
			conv_reg <= conv_pulse & ~sample_done;
			if (state_reg != DTUC_RUN || intv_tick || !intv_count)
				interval_cnt_reg <= interval_reg;
			else
				interval_cnt_reg <= dec16(interval_cnt_reg);
			// Counter 1 rise wins over the end of the interval
			if (state_reg != DTUC_RUN || cmd_arm)
				intv_go_reg <= 1'b0;
			else if (intv_w & gpc1_rise)
				intv_go_reg <= 1'b1;
			else if (timed_pulse)
				intv_go_reg <= 1'b0;
			// Load on the second conversion edge, two extra pulses
			if (cmd_arm)
			begin
				sample_loaded_reg   <= 1'b0;
				sample_clk_seen_reg <= 1'b0;
			end
			else if (conv_pulse & sample_gate)
			begin
				if (!sample_clk_seen_reg)
					sample_clk_seen_reg <= 1'b1;
				else if (!sample_loaded_reg)
				begin
					sample_loaded_reg <= 1'b1;
					sample_cnt_reg    <= count_reg;
				end
				else
					sample_cnt_reg <= dec16(sample_cnt_reg);
			end
		end
	end

	// DAC path: hold registers move to outputs per update mode
	wire upd_low = ~upd_lvl;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dac0_hold_reg <= DTUC_DAC_RST;
			dac1_hold_reg <= DTUC_DAC_RST;
			dac0_reg      <= DTUC_DAC_RST;
			dac1_reg      <= DTUC_DAC_RST;
		end
		else
		begin
			if (wr_dac0)
				dac0_hold_reg <= pwdata[11:0];
			if (wr_dac1)
				dac1_hold_reg <= pwdata[11:0];
			if (~later_w)
			begin
				if (wr_dac0)
					dac0_reg <= pwdata[11:0];
				if (wr_dac1)
					dac1_reg <= pwdata[11:0];
			end
			else if (upd_low)
			begin
				// Level-sensitive, so a write while low passes through
				dac0_reg <= wr_dac0 ? pwdata[11:0] : dac0_hold_reg;
				dac1_reg <= wr_dac1 ? pwdata[11:0] : dac1_hold_reg;
			end
		end
	end

	// Set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_reg <= 1'b0;
		else if (updint_w & upd_rise)
			irq_reg <= 1'b1;
		else if (int_clear)
			irq_reg <= 1'b0;
	end

	// Registers and APB answer, zero wait states
	wire [31:0] status_w = {24'h0000_00, 1'b0, state_reg, trig_seen_reg, upd_lvl, irq_reg, sample_loaded_reg};
	wire [31:0] rd_mux =
		hit_ctrl ? {24'h0000_00, ctrl_reg} :
		hit_int  ? {16'h0000, interval_reg} :
		hit_cnt  ? {16'h0000, count_reg} :
		hit_dac0 ? {20'h0_0000, dac0_hold_reg} :
		hit_dac1 ? {20'h0_0000, dac1_hold_reg} :
		hit_stat ? status_w :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg     <= DTUC_CTRL_RST;
			interval_reg <= DTUC_INTERVAL_RST;
			count_reg    <= DTUC_COUNT_RST;
			prdata_reg   <= 32'h0000_0000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= ctrl_wdata;
			if (wr_w & hit_int)
				interval_reg <= pwdata[15:0];
			if (wr_w & hit_cnt)
				count_reg <= pwdata[15:0];
			pready_reg  <= setup_w;
			pslverr_reg <= setup_w & ~hit_any;
			prdata_reg  <= (setup_w & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	assign prdata         = prdata_reg;
	assign pready         = pready_reg;
	assign pslverr        = pslverr_reg;
	assign adc_convert    = conv_reg;
	assign dac0_out       = dac0_reg;
	assign dac1_out       = dac1_reg;
	assign host_interrupt = irq_reg;

endmodule : dtuc_core

/* rtl/dtuc_pkg.sv */
/*
 Package for the conversion sequencing and DAC update block: register map,
 field positions, reset values, states and carriers.
 Assumes a single 125 MHz clock domain and an APB slave with 32-bit data.
*/
package dtuc_pkg;

	localparam logic [11:0] DTUC_OFF_CTRL     = 12'h000;
	localparam logic [11:0] DTUC_OFF_INTERVAL = 12'h004;
	localparam logic [11:0] DTUC_OFF_COUNT    = 12'h008;
	localparam logic [11:0] DTUC_OFF_DAC0     = 12'h00C;
	localparam logic [11:0] DTUC_OFF_DAC1     = 12'h010;
	localparam logic [11:0] DTUC_OFF_STATUS   = 12'h014;
	localparam logic [11:0] DTUC_OFF_CMD      = 12'h018;

	// Control register bit positions
	localparam int DTUC_CTRL_ENABLE    = 0;
	localparam int DTUC_CTRL_EXT_CONVERT_N   = 1;
	localparam int DTUC_CTRL_POSTTRIG  = 2;
	localparam int DTUC_CTRL_PRETRIGGER_MODE   = 3;
	localparam int DTUC_CTRL_FREERUN   = 4;
	localparam int DTUC_CTRL_INTERVAL  = 5;
	localparam int DTUC_CTRL_LATERUPD  = 6;
	localparam int DTUC_CTRL_UPDINT_EN = 7;
	localparam int DTUC_CTRL_WIDTH     = 8;

	// Command register bit positions
	localparam int DTUC_CMD_ARM      = 0;
	localparam int DTUC_CMD_INTCLR   = 1;

	localparam logic [7:0]  DTUC_CTRL_RST     = 8'h00;
	localparam logic [15:0] DTUC_INTERVAL_RST = 16'h0010;
	localparam logic [15:0] DTUC_COUNT_RST    = 16'h0003;
	localparam logic [11:0] DTUC_DAC_RST      = 12'h000;
	localparam int          DTUC_SYNC_STAGES  = 2;

	typedef enum logic [2:0] {
		DTUC_IDLE,
		DTUC_WAIT_TRIG,
		DTUC_WAIT_CONV_HIGH,
		DTUC_RUN,
		DTUC_DONE
	} dtuc_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dtuc_apb_req_t;

	typedef struct packed {
		logic        prdata_valid;
		logic [31:0] prdata;
		logic        pslverr;
	} dtuc_apb_rsp_t;

endpackage : dtuc_pkg

/* rtl/dtuc_sync.sv */
/*
 Two-stage synchroniser with edge detection behind the second stage.
 Assumes the input is asynchronous to pclk and idles at RST_VAL.
*/
module dtuc_sync
	import dtuc_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// First stage feeds only the second stage
	// Reset to the idle level, so release gives no false edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
			last_reg <= RST_VAL;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
	assign fall  = ~sync_reg & last_reg;

endmodule : dtuc_sync
